// ---- hdl/msp_input_regs.vh ----
// Constants for the multimode serializer parallel input front end.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef MSP_INPUT_REGS_VH
`define MSP_INPUT_REGS_VH

// Register indices on the host serial port register interface
`define MSP_OFS_PROC_DISABLE   8'h00
`define MSP_OFS_STATUS         8'h01
`define MSP_OFS_FORMAT_LOWER   8'h0A
`define MSP_OFS_FORMAT_UPPER   8'h0B

// Reset values
`define MSP_RST_PROC_DISABLE   4'h0
`define MSP_RST_FORMAT_LOWER   16'h0000
`define MSP_RST_FORMAT_UPPER   16'h0000

// Processing disable bits
`define MSP_DIS_PKT_INSERT     0
`define MSP_DIS_STD_DETECT     1
`define MSP_DIS_CRC_INSERT     2
`define MSP_DIS_EDH_INSERT     3

// Status register fields
`define MSP_ST_MODE_LSB        0
`define MSP_ST_MODE_MSB        2
`define MSP_ST_PCLK_LOST       3
`define MSP_ST_NARROW_BUS      4
`define MSP_ST_RATE_SD         5

// Data bus field positions
`define MSP_LUMA_MSB           19
`define MSP_LUMA_LSB           10
`define MSP_CHROMA_MSB         9
`define MSP_CHROMA_LSB         0
`define MSP_TS_SYNC_BIT        19
`define MSP_TS_KCHAR_BIT       18
`define MSP_TS_BYTE_MSB        17
`define MSP_TS_BYTE_LSB        10

// Word that opens a timing reference sequence
`define MSP_TRS_PREAMBLE       10'h3FF

// Timing: lost-clock detection
`define MSP_CLK_PERIOD_NS      100
`define MSP_LOSS_TIME_NS       4000
`define MSP_LOSS_CYCLES        (`MSP_LOSS_TIME_NS / `MSP_CLK_PERIOD_NS)

`endif

// ---- hdl/msp_clk_mon.v ----
// Parallel clock monitor: synchronises the parallel clock pin, finds
// its rising edges and flags loss of the clock.
// Assumes the system clock runs well above twice the parallel clock.
`timescale 1ns/100ps
`default_nettype none
`include "msp_input_regs.vh"

module msp_clk_mon
(
   // System
   input  wire        clock,
   input  wire        rstn,
   // Parallel clock pin
   input  wire        pclk_pin,
   // Results
   output reg         pclk_rise_ff,
   output reg         pclk_lost_ff
);

   localparam integer LOSS_INT   = `MSP_LOSS_CYCLES;
   localparam [7:0]   LOSS_CYCLES = LOSS_INT[7:0];

   reg         sync1_ff;
   reg         sync2_ff;
   reg         prev_ff;
   reg  [7:0]  idle_cnt_ff;
   wire        rise;

   assign rise = sync2_ff & ~prev_ff;

   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_ff     <= 1'b0;
         sync2_ff     <= 1'b0;
         prev_ff      <= 1'b0;
         idle_cnt_ff  <= 8'h00;
         pclk_rise_ff <= 1'b0;
         pclk_lost_ff <= 1'b1;
      end
      else
      begin
         sync1_ff     <= pclk_pin;
         sync2_ff     <= sync1_ff;
         prev_ff      <= sync2_ff;
         pclk_rise_ff <= rise;
         // Lost until the first edge; a stalled clock mutes again
         if (rise)
         begin
            idle_cnt_ff  <= 8'h00;
            pclk_lost_ff <= 1'b0;
         end
         else if (idle_cnt_ff >= LOSS_CYCLES - 8'h01)
            pclk_lost_ff <= 1'b1;
         else
            idle_cnt_ff  <= idle_cnt_ff + 8'h01;
      end
   end

endmodule // msp_clk_mon
`default_nettype wire

// ---- hdl/msp_input.v ----
// Parallel input front end of the multimode serializer.
// Assumes the pins come from outside the system clock domain and the
// register port comes from the host serial port decoder on clock.
`timescale 1ns/100ps
`default_nettype none
`include "msp_input_regs.vh"

module msp_input
(
   // System
   input  wire        clock,
   input  wire        rstn,
   // Parallel input pins
   input  wire        pclk_pin,
   input  wire [19:0] din_pin,
   // Mode select pins
   input  wire        bus_width_select,
   input  wire        rate_select,
   input  wire        video_coding_select,
   input  wire        transport_mode_select,
   // Register port from the host serial port decoder
   input  wire [7:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_we,
   input  wire        reg_re,
   output reg  [15:0] reg_rdata_ff,
   // Internal datapath
   output reg  [19:0] word_ff,
   output reg         word_valid_ff,
   output reg  [2:0]  mode_ff,
   output reg         wide_bus_ff,
   output reg         rate_sd_ff,
   output reg         scramble_en_ff,
   output reg         encode_8b10b_en_ff,
   output reg         output_mute_ff,
   // Transport stream fields
   output reg  [7:0]  ts_byte_ff,
   output reg         sync_insert_request_ff,
   output reg         special_char_flag_ff,
   // Video processing enables
   output reg  [3:0]  proc_enable_ff,
   // Format payload to packet insertion
   output reg  [15:0] format_upper_ff,
   output reg  [15:0] format_lower_ff
);

   localparam [2:0] MODE_VIDEO = 3'h1;
   localparam [2:0] MODE_TS    = 3'h2;
   localparam [2:0] MODE_THRU  = 3'h4;

   // Two-flop synchronisers on all pin inputs
   reg  [19:0] din_s1_ff;
   reg  [19:0] din_s2_ff;
   reg  [3:0]  pins_s1_ff;
   reg  [3:0]  pins_s2_ff;

   reg  [3:0]  proc_dis_ff;
   reg  [9:0]  chroma_hold_ff;
   reg         phase_ff;
   reg  [2:0]  nxt_mode;
   reg  [15:0] nxt_rdata;

   wire        pclk_rise;
   wire        pclk_lost;
   wire [9:0]  upper;
   wire [9:0]  lower;
   wire        boundary;

   function [2:0] decode_mode;
      input coding;
      input ts;
      begin
         if (coding && !ts)
            decode_mode = MODE_VIDEO;
         else if (!coding && ts)
            decode_mode = MODE_TS;
         else
            decode_mode = MODE_THRU;
      end
   endfunction

   msp_clk_mon u_clk_mon
   (
      .clock        (clock),
      .rstn         (rstn),
      .pclk_pin     (pclk_pin),
      .pclk_rise_ff (pclk_rise),
      .pclk_lost_ff (pclk_lost)
   );

   assign upper    = din_s2_ff[`MSP_LUMA_MSB:`MSP_LUMA_LSB];
   assign lower    = din_s2_ff[`MSP_CHROMA_MSB:`MSP_CHROMA_LSB];
   // Mid-pair mode changes would split a luma/chroma pair
   assign boundary = pclk_rise & ~phase_ff;

   always @*
   begin
      nxt_mode = decode_mode(pins_s2_ff[2], pins_s2_ff[3]);
   end

   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         din_s1_ff  <= 20'h00000;
         din_s2_ff  <= 20'h00000;
         pins_s1_ff <= 4'h0;
         pins_s2_ff <= 4'h0;
      end
      else
      begin
         din_s1_ff  <= din_pin;
         din_s2_ff  <= din_s1_ff;
         pins_s1_ff <= {transport_mode_select, video_coding_select,
                        rate_select, bus_width_select};
         pins_s2_ff <= pins_s1_ff;
      end
   end

   // Mode pins are taken only at a word boundary
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_ff            <= MODE_THRU;
         wide_bus_ff        <= 1'b0;
         rate_sd_ff         <= 1'b0;
         scramble_en_ff     <= 1'b0;
         encode_8b10b_en_ff <= 1'b0;
      end
      else if (boundary)
      begin
         mode_ff            <= nxt_mode;
         wide_bus_ff        <= pins_s2_ff[0];
         rate_sd_ff         <= pins_s2_ff[1];
         scramble_en_ff     <= (nxt_mode == MODE_VIDEO);
         encode_8b10b_en_ff <= (nxt_mode == MODE_TS);
      end
   end

   // Capture and width adaptation of each parallel word
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         word_ff                <= 20'h00000;
         word_valid_ff          <= 1'b0;
         chroma_hold_ff         <= 10'h000;
         phase_ff               <= 1'b0;
         ts_byte_ff             <= 8'h00;
         sync_insert_request_ff <= 1'b0;
         special_char_flag_ff   <= 1'b0;
      end
      else
      begin
         word_valid_ff <= 1'b0;
         if (pclk_rise)
         begin
            case (mode_ff)
               MODE_VIDEO:
               begin
                  if (wide_bus_ff)
                  begin
                     word_ff       <= {upper, lower};
                     word_valid_ff <= 1'b1;
                     phase_ff      <= 1'b0;
                  end
                  else if (!phase_ff || upper == `MSP_TRS_PREAMBLE)
                  begin
                     // Preamble restarts pairing so lines stay aligned
                     chroma_hold_ff <= upper;
                     phase_ff       <= 1'b1;
                  end
                  else
                  begin
                     word_ff       <= {upper, chroma_hold_ff};
                     word_valid_ff <= 1'b1;
                     phase_ff      <= 1'b0;
                  end
               end
               MODE_TS:
               begin
                  // Lower inputs are never looked at here
                  ts_byte_ff <=
                     din_s2_ff[`MSP_TS_BYTE_MSB:`MSP_TS_BYTE_LSB];
                  sync_insert_request_ff <= din_s2_ff[`MSP_TS_SYNC_BIT];
                  special_char_flag_ff <= din_s2_ff[`MSP_TS_KCHAR_BIT];
                  word_ff       <= {upper, 10'h000};
                  word_valid_ff <= 1'b1;
                  phase_ff      <= 1'b0;
               end
               default:
               begin
                  if (wide_bus_ff)
                     word_ff <= din_s2_ff;
                  else
                     word_ff <= {upper, 10'h000};
                  word_valid_ff <= 1'b1;
                  phase_ff      <= 1'b0;
               end
            endcase
         end
      end
   end

   // Output mute and gated processing enables
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         output_mute_ff <= 1'b1;
         proc_enable_ff <= 4'h0;
      end
      else
      begin
         output_mute_ff <= pclk_lost;
         if (mode_ff == MODE_VIDEO)
            proc_enable_ff <= ~proc_dis_ff;
         else
            proc_enable_ff <= 4'h0;
      end
   end

   // Register writes
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         proc_dis_ff     <= `MSP_RST_PROC_DISABLE;
         format_upper_ff <= `MSP_RST_FORMAT_UPPER;
         format_lower_ff <= `MSP_RST_FORMAT_LOWER;
      end
      else if (reg_we)
      begin
         if (reg_addr == `MSP_OFS_PROC_DISABLE)
            proc_dis_ff <= reg_wdata[3:0];
         else if (reg_addr == `MSP_OFS_FORMAT_UPPER)
            format_upper_ff <= reg_wdata;
         else if (reg_addr == `MSP_OFS_FORMAT_LOWER)
            format_lower_ff <= reg_wdata;
      end
   end

   // Register reads; unmapped indices read zero
   always @*
   begin
      nxt_rdata = 16'h0000;
      if (reg_addr == `MSP_OFS_PROC_DISABLE)
         nxt_rdata = {12'h000, proc_dis_ff};
      else if (reg_addr == `MSP_OFS_STATUS)
      begin
         nxt_rdata[`MSP_ST_MODE_MSB:`MSP_ST_MODE_LSB] = mode_ff;
         nxt_rdata[`MSP_ST_PCLK_LOST]  = output_mute_ff;
         nxt_rdata[`MSP_ST_NARROW_BUS] = ~wide_bus_ff;
         nxt_rdata[`MSP_ST_RATE_SD]    = rate_sd_ff;
      end
      else if (reg_addr == `MSP_OFS_FORMAT_UPPER)
         nxt_rdata = format_upper_ff;
      else if (reg_addr == `MSP_OFS_FORMAT_LOWER)
         nxt_rdata = format_lower_ff;
   end

   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         reg_rdata_ff <= 16'h0000;
      else if (reg_re)
         reg_rdata_ff <= nxt_rdata;
   end

endmodule // msp_input
`default_nettype wire

// ---- bench/msp_input_asserts.sv ----
// Checker for msp_input, bound to its ports.
// Assumes clock samples the asynchronous parallel clock pin.
`timescale 1ns/100ps
`default_nettype none
module msp_input_asserts
(
   // System
   input wire logic        clock,
   input wire logic        rstn,
   // Observed ports
   input wire logic        pclk_pin,
   input wire logic [19:0] word_ff,
   input wire logic        word_valid_ff,
   input wire logic [2:0]  mode_ff,
   input wire logic        scramble_en_ff,
   input wire logic        encode_8b10b_en_ff,
   input wire logic        output_mute_ff,
   input wire logic [3:0]  proc_enable_ff
);
   logic       pin_ff;
   logic [5:0] idle_ff;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Cycles since the clock pin last moved, saturating
   always @(posedge clock or negedge rstn)
      if (!rstn)
      begin
         pin_ff  <= 1'b0;
         idle_ff <= 6'h00;
      end
      else
      begin
         pin_ff <= pclk_pin;
         if (pclk_pin != pin_ff)
            idle_ff <= 6'h00;
         else if (idle_ff != 6'h3F)
            idle_ff <= idle_ff + 6'h01;
      end
   // Mode held long enough that no boundary word is in flight
   sequence s_video;
      (mode_ff == 3'h1) [*8];
   endsequence
   sequence s_ts;
      (mode_ff == 3'h2) [*8];
   endsequence
   a_valid_one_cycle: assert property (word_valid_ff |=> !word_valid_ff)
      else $error("word valid longer than one cycle");
   a_mode_one_hot: assert property ($onehot(mode_ff))
      else $error("mode not one-hot");
   a_video_scramble: assert property (s_video |-> scramble_en_ff
      && !encode_8b10b_en_ff) else $error("video enables wrong");
   a_ts_encode: assert property (s_ts |-> encode_8b10b_en_ff
      && !scramble_en_ff) else $error("transport enables wrong");
   // Processing enables follow mode_ff one cycle later
   a_proc_video_only: assert property (mode_ff != 3'h1
      |=> proc_enable_ff == 4'h0) else $error("processing on outside video");
   a_ts_low_ignored: assert property (s_ts ##0 word_valid_ff
      |-> word_ff[9:0] == 10'h000) else $error("low bus used in transport");
   a_mute_clears: assert property ($rose(pclk_pin)
      |-> ##[1:6] !output_mute_ff) else $error("mute not cleared");
   a_mute_on_loss: assert property (idle_ff >= 6'h2D |-> output_mute_ff)
      else $error("mute missing on clock loss");
endmodule // msp_input_asserts
bind msp_input msp_input_asserts chk_u (.clock, .rstn, .pclk_pin, .word_ff,
   .word_valid_ff, .mode_ff, .scramble_en_ff, .encode_8b10b_en_ff,
   .output_mute_ff, .proc_enable_ff);
`default_nettype wire

// ---- bench/msp_src_model.sv ----
// Upstream source model: parallel clock pin and data bus.
// Assumes the bench calls put_word; the clock stands still between words.
`timescale 1ns/100ps
`default_nettype none
module msp_src_model
(
   // Link pins
   output var logic        pclk_pin,
   output var logic [19:0] din_pin
);
   initial
   begin
      pclk_pin = 1'b0;
      din_pin  = 20'h00000;
   end
   // 800 ns per word, data stable for the whole period around the rise
   task put_word(input logic [19:0] w);
   begin
      din_pin = w;
      #400 pclk_pin = 1'b1;
      #400 pclk_pin = 1'b0;
   end
   endtask
endmodule // msp_src_model
`default_nettype wire

// ---- bench/tb_msp_input.sv ----
// Self-checking bench for msp_input: pins, registers, clock loss.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module tb_msp_input;
   logic        clock, rstn, pclk_pin, reg_we, reg_re;
   logic [19:0] din_pin, word_ff, w, a;
   logic        bus_width_select, rate_select;
   logic        video_coding_select, transport_mode_select;
   logic [7:0]  reg_addr, ts_byte_ff;
   logic [15:0] reg_wdata, reg_rdata_ff, format_upper_ff, format_lower_ff;
   logic        word_valid_ff, wide_bus_ff, rate_sd_ff, scramble_en_ff;
   logic        encode_8b10b_en_ff, output_mute_ff;
   logic        sync_insert_request_ff, special_char_flag_ff;
   logic [2:0]  mode_ff;
   logic [3:0]  proc_enable_ff;
   logic [19:0] exp_q[$];
   int          err_total, tests_run, i;
   msp_src_model src_u (.pclk_pin, .din_pin);
   msp_input dut_u (.clock, .rstn, .pclk_pin, .din_pin, .bus_width_select,
      .rate_select, .video_coding_select, .transport_mode_select, .reg_addr,
      .reg_wdata, .reg_we, .reg_re, .reg_rdata_ff, .word_ff, .word_valid_ff,
      .mode_ff, .wide_bus_ff, .rate_sd_ff, .scramble_en_ff,
      .encode_8b10b_en_ff, .output_mute_ff, .ts_byte_ff,
      .sync_insert_request_ff, .special_char_flag_ff, .proc_enable_ff,
      .format_upper_ff, .format_lower_ff);
   always #50 clock = ~clock;
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
   begin
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task test_done;
   begin
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   task wr(input logic [7:0] ad, input logic [15:0] d);
   begin
      @(posedge clock) #1;
      reg_addr  = ad;
      reg_wdata = d;
      reg_we    = 1'b1;
      @(posedge clock) #1;
      reg_we = 1'b0;
      @(posedge clock) #1;
   end
   endtask
   task rd(input logic [7:0] ad, input logic [15:0] e);
   begin
      @(posedge clock) #1;
      reg_addr = ad;
      reg_re   = 1'b1;
      @(posedge clock) #1;
      reg_re = 1'b0;
      chk(reg_rdata_ff, e);
   end
   endtask
   // One spare word lets the new mode land on a word boundary
   task set_mode(input logic c, input logic t, input logic wd);
   begin
      video_coding_select   = c;
      transport_mode_select = t;
      bus_width_select      = wd;
      rate_select           = $urandom;
      src_u.put_word(20'h00000);
      // Spare word's result passes while no note is queued
      @(posedge clock) #1;
   end
   endtask
   task send(input logic [19:0] wd, input logic [19:0] e, input logic p);
   begin
      if (p)
         exp_q.push_back(e);
      src_u.put_word(wd);
   end
   endtask
   // Transport results are repacked as bus bits 19..10 with zeros above
   always @(negedge clock)
      if (word_valid_ff === 1'b1 && exp_q.size() > 0)
         chk(mode_ff[1] ? {word_ff[9:0], sync_insert_request_ff,
            special_char_flag_ff, ts_byte_ff} : word_ff,
            exp_q.pop_front());
   initial
   begin
      #2000000;
      err_total++;
      test_done;
   end
   initial
   begin
      {clock, rstn, reg_we, reg_re, reg_addr, reg_wdata} = '0;
      {bus_width_select, rate_select} = 2'h0;
      {video_coding_select, transport_mode_select} = 2'h0;
      void'($urandom(32'h1E343729));
      repeat (8) @(posedge clock);
      #1 rstn = 1'b1;
      chk(output_mute_ff, 1'b1);
      chk(mode_ff, 3'h4);
      rd(8'h00, 16'h0000);
      rd(8'h0A, 16'h0000);
      rd(8'h0B, 16'h0000);
      rd(8'h05, 16'h0000);
      $display("Test reset done");
      set_mode(1'b1, 1'b0, 1'b1);
      repeat (4)
      begin
         w = $urandom;
         send(w, w, 1'b1);
      end
      chk(scramble_en_ff, 1'b1);
      chk(wide_bus_ff, 1'b1);
      chk(proc_enable_ff, 4'hF);
      wr(8'h00, 16'h0005);
      chk(proc_enable_ff, 4'hA);
      wr(8'h01, 16'hFFFF);
      rd(8'h01, {10'h000, rate_select, 5'h01});
      rd(8'h00, 16'h0005);
      $display("Test wide video done");
      set_mode(1'b1, 1'b0, 1'b0);
      repeat (3)
      begin
         a = $urandom & 20'h7FFFF;
         w = $urandom & 20'h7FFFF;
         send(a, 20'h0, 1'b0);
         send(w, {w[19:10], a[19:10]}, 1'b1);
      end
      send(a, 20'h0, 1'b0);
      send({10'h3FF, a[9:0]}, 20'h0, 1'b0);
      send(w, {w[19:10], 10'h3FF}, 1'b1);
      $display("Test narrow video done");
      set_mode(1'b0, 1'b1, 1'b0);
      repeat (6)
      begin
         w = $urandom;
         send(w, {10'h000, w[19:10]}, 1'b1);
      end
      chk(encode_8b10b_en_ff, 1'b1);
      $display("Test transport done");
      for (i = 0; i < 3; i++)
      begin
         set_mode(i[1], i[1], i[0]);
         repeat (3)
         begin
            w = $urandom;
            send(w, i[0] ? w : {w[19:10], 10'h000}, 1'b1);
         end
         chk(mode_ff, 3'h4);
      end
      $display("Test pass-through done");
      w = $urandom;
      wr(8'h0A, w[15:0]);
      wr(8'h0B, ~w[15:0]);
      rd(8'h0A, w[15:0]);
      rd(8'h0B, ~w[15:0]);
      chk(format_upper_ff, {4'h0, ~w[15:0]});
      chk(format_lower_ff, {4'h0, w[15:0]});
      $display("Test format registers done");
      repeat (60) @(posedge clock);
      chk(output_mute_ff, 1'b1);
      send(w, {w[19:10], 10'h000}, 1'b1);
      repeat (2) @(posedge clock);
      #1 chk(output_mute_ff, 1'b0);
      chk(exp_q.size(), 20'h0);
      $display("Test clock loss done");
      test_done;
   end
endmodule // tb_msp_input
`default_nettype wire
